/* pm_dual_ram.sv */
// 8k x 24 on-chip program ram, one read port for opcode, one read/write for data
// assumes a single clock; read data are registered
`timescale 1ns/10ps
module pm_dual_ram #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8192,
  parameter int AW    = 13
) (
  input  wire logic             sys_clk,
  input  wire logic [AW-1:0]    fetch_addr,
  output logic      [WIDTH-1:0] fetch_rdata,
  input  wire logic             data_en,
  input  wire logic             data_we,
  input  wire logic [AW-1:0]    data_addr,
  input  wire logic [WIDTH-1:0] data_wdata,
  output logic      [WIDTH-1:0] data_rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // both ports served in the same cycle
  always_ff @(posedge sys_clk) begin
    fetch_rdata <= mem[fetch_addr];
    if (data_en) begin
      if (data_we) begin
        mem[data_addr] <= data_wdata;
      end
      data_rdata <= mem[data_addr];
    end
  end
endmodule // pm_dual_ram

/* pm_ext_overlay_mem.sv */
// external overlay memory model with programmable wait
// assumes one external cycle at a time
`timescale 1ns/10ps
module pm_ext_overlay_mem (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [3:0]  wait_cycles,
  input wire logic        ext_sel,
  input wire logic        ext_we,
  input wire logic        ext_addr_top_bit,
  input wire logic [12:0] ext_addr_low,
  input wire logic [23:0] ext_wdata,
  output logic            ext_ack,
  output logic [23:0]     ext_rdata
);
  logic [23:0] mem [0:16383];
  logic [3:0]  cnt_q;
  logic        done_q;
  logic [13:0] addr;
  assign addr = {ext_addr_top_bit, ext_addr_low};
  initial begin
    for (int i = 0; i < 16384; i++) mem[i] = 24'hA00000 | 24'(i);
  end
  // bus idle: data toggles so a stale word never passes
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      done_q <= 1'h0;
      ext_ack <= 1'h0;
      ext_rdata <= 24'h5A5A5A;
    end else if (ext_sel && !ext_ack && !done_q && cnt_q != wait_cycles) begin
      cnt_q <= cnt_q + 4'h1;
      ext_rdata <= ~ext_rdata;
    end else if (ext_sel && !ext_ack && !done_q) begin
      ext_ack <= 1'h1;
      done_q <= 1'h1;
      cnt_q <= 4'h0;
      if (ext_we) mem[addr] <= ext_wdata;
      else ext_rdata <= mem[addr];
    end else begin
      ext_ack <= 1'h0;
      ext_rdata <= ~ext_rdata;
      if (!ext_sel) done_q <= 1'h0;
    end
  end
endmodule // pm_ext_overlay_mem

/* pm_ext_strap.sv */
// samples the map-mode strap pin through three flops
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/10ps
module pm_ext_strap (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level_q
);
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic       level_d;

  always_comb begin
    sync_d  = {sync_q[1:0], pin};
    level_d = level_q;
    // change only counted once stages two and three agree
    if (sync_q[2] == sync_q[1]) begin
      level_d = sync_q[2];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_q  <= 3'h0;
      level_q <= 1'h0;
    end else begin
      sync_q  <= sync_d;
      level_q <= level_d;
    end
  end
endmodule // pm_ext_strap

/* pm_overlay_pkg.sv */
// constants for the program memory overlay decoder
// assumes a 14-bit program address space and 24-bit words
package pm_overlay_pkg;
  localparam int          ADDR_W        = 14;
  localparam int          LOW_W         = 13;
  localparam int          WORD_W        = 24;
  localparam int          RAM_DEPTH     = 8192;
  localparam int          OVL_W         = 2;
  localparam logic [1:0]  OVL_INTERNAL  = 2'h0;
  localparam logic [1:0]  OVL_SEG_ONE   = 2'h1;
  localparam logic [1:0]  OVL_SEG_TWO   = 2'h2;
  localparam logic        WINDOW_BIT_HI = 1'h1;
  localparam int          TOP_BIT       = 13;
  localparam logic [23:0] UNDEF_WORD    = 24'h000000;
  localparam logic [23:0] WORD_RESET    = 24'h000000;
  localparam logic [13:0] ADDR_RESET    = 14'h0000;
endpackage

/* pm_ovl_chk_asserts.sv */
// assertions on the overlay decoder ports
// assumes the strap is steady while traffic runs
`timescale 1ns/10ps
module pm_ovl_chk
  import pm_overlay_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [1:0]  program_overlay_select,
  input wire logic        fetch_req,
  input wire logic [13:0] fetch_addr,
  input wire logic        data_req,
  input wire logic        fetch_valid,
  input wire logic        data_valid,
  input wire logic        ext_sel,
  input wire logic        ext_addr_top_bit,
  input wire logic [12:0] ext_addr_low,
  input wire logic        ext_ack,
  input wire logic        boot_enable,
  input wire logic        stall
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence ext_start;
    $rose(ext_sel) && boot_enable;
  endsequence
  sequence ext_done;
    ext_sel && ext_ack;
  endsequence
  ////////////////////////////////////////////////////////////////
  chk_seg_one_bit: assert property (
    ext_start ##0 $past(program_overlay_select) == OVL_SEG_ONE |-> !ext_addr_top_bit)
    else $error("top bit not low");
  chk_seg_two_bit: assert property (
    ext_start ##0 $past(program_overlay_select) == OVL_SEG_TWO |-> ext_addr_top_bit)
    else $error("top bit not high");
  chk_sel_zero_int: assert property (
    ext_start |-> $past(program_overlay_select) != OVL_INTERNAL)
    else $error("external cycle with select zero");
  chk_low_addr: assert property (
    ext_start ##0 $past(fetch_req) && $past(fetch_addr[13])
    |-> ext_addr_low == $past(fetch_addr[12:0]))
    else $error("low address wrong");
  chk_ext_hold: assert property (
    ext_sel && !ext_ack |=> ext_sel && $stable(ext_addr_low) && $stable(ext_addr_top_bit))
    else $error("external address moved");
  chk_ext_release: assert property (
    ext_done |=> !ext_sel && !stall)
    else $error("external cycle not released");
  chk_ext_answer: assert property (
    ext_done |-> ##2 (fetch_valid || data_valid))
    else $error("external answer late");
  chk_int_one_pass: assert property (
    fetch_req && !data_req && !stall && !ext_sel && boot_enable && !fetch_addr[13]
    |-> ##2 fetch_valid)
    else $error("internal fetch late");
  chk_reserved_quiet: assert property (
    !boot_enable && fetch_req && !data_req && !stall && fetch_addr[13] |=> !ext_sel)
    else $error("reserved access went external");
endmodule // pm_ovl_chk

bind program_memory_overlay_decoder pm_ovl_chk u_chk (
  .sys_clk, .rst, .program_overlay_select, .fetch_req, .fetch_addr, .data_req,
  .fetch_valid, .data_valid, .ext_sel, .ext_addr_top_bit, .ext_addr_low,
  .ext_ack, .boot_enable, .stall
);

/* program_memory_overlay_decoder.sv */
// What this block does
// R1: 8K on-chip program ram plus up to two external 8K overlay segments.
// R2: every program word is 24 bits, opcode or data.
// R3: on-chip ram takes two accesses per cycle.
// R4: opcode and data operand both delivered in one cycle.
// R5: strap low: internal ram at 0x0000-0x1FFF, overlay window above.
// R6: overlay select zero: internal only, no external cycles.
// R7: overlay select nonzero: 0x2000-0x3FFF go external.
// R8: top address bit 0 for overlay 1, 1 for overlay 2; low 13 from address.
// R9: segments use only the normal 14 external address bits.
// R10: software avoids 0x2000-0x3FFF while overlay select is zero.
// R11: sequencer and loops ignore overlay select value.
// R12: overlay select is not stacked on interrupts.
// R13: strap high disables booting and overlays; software keeps select zero.
// R14: strap high: external 8K at 0x0000-0x1FFF, upper half reserved.
// R15: reserved access in strap-high mode: no external cycle, undefined data.
//
// program memory decoder: two requesters (fetch, data), internal ram and external bus
// assumes the core holds the external bus request until ext_ack; one external cycle at a time
`timescale 1ns/10ps
module program_memory_overlay_decoder
  import pm_overlay_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   map_mode_pin,
  input  wire logic [1:0]             program_overlay_select,
  input  wire logic                   fetch_req,
  input  wire logic [13:0]            fetch_addr,
  output logic      [23:0]            fetch_rdata,
  output logic                        fetch_valid,
  input  wire logic                   data_req,
  input  wire logic                   data_we,
  input  wire logic [13:0]            data_addr,
  input  wire logic [23:0]            data_wdata,
  output logic      [23:0]            data_rdata,
  output logic                        data_valid,
  output logic                        ext_sel,
  output logic                        ext_we,
  output logic                        ext_addr_top_bit,
  output logic      [12:0]            ext_addr_low,
  output logic      [23:0]            ext_wdata,
  input  wire logic                   ext_ack,
  input  wire logic [23:0]            ext_rdata,
  output logic                        boot_enable,
  output logic                        stall
);
  import pm_overlay_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXT  = 2'b01
  } ext_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // target decode
  typedef enum logic [1:0] {
    TGT_INT  = 2'b00,
    TGT_EXT  = 2'b01,
    TGT_RSVD = 2'b11
  } target_e;

  ////////////////////////////////////////////////////////////////////////////
  // map-mode strap; a pin that moves while traffic runs changes the map between accesses
  logic map_hi;

  pm_ext_strap u_strap (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin     (map_mode_pin),
    .level_q (map_hi)
  );

  function automatic target_e decode(input logic [13:0] a, input logic m, input logic [1:0] ov);
    target_e t;
    // R5 low half internal
    // strap low and address below the window: the on-chip ram answers
    t = TGT_INT;
    if (m) begin
      // R14 upper reserved
      t = a[TOP_BIT] ? TGT_RSVD : TGT_EXT;
    end else if (a[TOP_BIT]) begin
      // R6 select zero
      // R7 window external
      t = (ov == OVL_INTERNAL) ? TGT_RSVD : TGT_EXT;
    end
    return t;
  endfunction

  // R8 segment top bit
  function automatic logic top_bit(input logic [13:0] a, input logic m, input logic [1:0] ov);
    logic b;
    b = 1'b0;
    if (!m) begin
      b = (ov == OVL_SEG_TWO);
    end else begin
      b = a[TOP_BIT];
    end
    return b;
  endfunction

  // R11 sequencer unaware
  // R12 no stacking
  // select is sampled live per access; the core owns its save/restore and loop hazards
  // R13 overlay ignored
  logic [1:0] ovl_eff;
  // forcing zero here keeps a stray select from reaching the bus in strap-high mode
  assign ovl_eff = map_hi ? OVL_INTERNAL : program_overlay_select;

  target_e fetch_tgt;
  target_e data_tgt;
  assign fetch_tgt = decode(fetch_addr, map_hi, ovl_eff);
  assign data_tgt  = decode(data_addr, map_hi, ovl_eff);

  ////////////////////////////////////////////////////////////////////////////
  // on-chip ram
  logic [23:0] ram_fetch;
  logic [23:0] ram_data;
  logic        data_int;
  logic        data_int_go;
  assign data_int = data_req && (data_tgt == TGT_INT);

  // R1 on-chip ram
  // R2 24-bit words
  // R3 dual access
  pm_dual_ram #(
    .WIDTH (WORD_W),
    .DEPTH (RAM_DEPTH),
    .AW    (LOW_W)
  ) u_ram (
    .sys_clk     (sys_clk),
    .fetch_addr  (fetch_addr[12:0]),
    .fetch_rdata (ram_fetch),
    .data_en     (data_int_go),
    .data_we     (data_we),
    .data_addr   (data_addr[12:0]),
    .data_wdata  (data_wdata),
    .data_rdata  (ram_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // external access sequencing, fetch first
  ext_state_e st_q, st_d;
  logic       own_fetch_q, own_fetch_d;
  logic       ext_sel_d, ext_we_d, top_d;
  logic [12:0] low_d;
  logic [23:0] wdata_d;
  logic       fetch_ext, data_ext;
  logic       fetch_int_q, data_int_q, fetch_int_d, data_int_d;
  logic       fetch_rsvd_q, data_rsvd_q, fetch_rsvd_d, data_rsvd_d;
  logic       ext_fdone_q, ext_ddone_q, ext_fdone_d, ext_ddone_d;
  logic [23:0] ext_hold_q, ext_hold_d;
  logic       stall_d;
  logic       boot_d;

  assign fetch_ext = fetch_req && (fetch_tgt == TGT_EXT);
  assign data_ext  = data_req && (data_tgt == TGT_EXT);
  // internal accesses of a cycle that goes external, or of a stalled cycle, are dropped: no valid, and no ram access on the data port (the fetch port reads anyway)
  assign data_int_go = data_int && (st_q == ST_IDLE) && !fetch_ext && !data_ext;

  always_comb begin
    st_d        = st_q;
    own_fetch_d = own_fetch_q;
    ext_sel_d   = ext_sel;
    ext_we_d    = ext_we;
    top_d       = ext_addr_top_bit;
    low_d       = ext_addr_low;
    wdata_d     = ext_wdata;
    ext_fdone_d = 1'b0;
    ext_ddone_d = 1'b0;
    ext_hold_d  = ext_hold_q;
    fetch_int_d = 1'b0;
    data_int_d  = 1'b0;
    fetch_rsvd_d = 1'b0;
    data_rsvd_d  = 1'b0;
    stall_d     = 1'b0;
    boot_d      = !map_hi;
    case (st_q)
      ST_IDLE: begin
        if (fetch_ext || data_ext) begin
          // fetch wins when both go external; the data request is dropped with no valid and is not retried here
          // R9 fourteen address bits
          st_d        = ST_EXT;
          own_fetch_d = fetch_ext;
          ext_sel_d   = 1'b1;
          ext_we_d    = !fetch_ext && data_we;
          top_d       = fetch_ext ? top_bit(fetch_addr, map_hi, ovl_eff)
                                  : top_bit(data_addr, map_hi, ovl_eff);
          low_d       = fetch_ext ? fetch_addr[12:0] : data_addr[12:0];
          wdata_d     = data_wdata;
          stall_d     = 1'b1;
        end else begin
          // R4 single cycle
          fetch_int_d  = fetch_req && (fetch_tgt == TGT_INT);
          data_int_d   = data_int;
          // R15 reserved no cycle
          fetch_rsvd_d = fetch_req && (fetch_tgt == TGT_RSVD);
          data_rsvd_d  = data_req && (data_tgt == TGT_RSVD);
        end
      end
      ST_EXT: begin
        // no timeout: a far side that never acknowledges holds the core stalled
        stall_d = 1'b1;
        if (ext_ack) begin
          st_d        = ST_IDLE;
          ext_sel_d   = 1'b0;
          ext_we_d    = 1'b0;
          // word caught at the ack edge; the far side may drop it right after
          ext_hold_d  = ext_rdata;
          ext_fdone_d = own_fetch_q;
          ext_ddone_d = !own_fetch_q;
          stall_d     = 1'b0;
        end
      end
      default: begin
        // unreachable codes fall back to idle with the bus released
        st_d      = ST_IDLE;
        ext_sel_d = 1'b0;
        ext_we_d  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q             <= ST_IDLE;
      own_fetch_q      <= 1'b0;
      ext_sel          <= 1'b0;
      ext_we           <= 1'b0;
      ext_addr_top_bit <= 1'b0;
      ext_addr_low     <= ADDR_RESET[LOW_W-1:0];
      ext_wdata        <= WORD_RESET;
      ext_fdone_q      <= 1'b0;
      ext_ddone_q      <= 1'b0;
      ext_hold_q       <= WORD_RESET;
      fetch_int_q      <= 1'b0;
      data_int_q       <= 1'b0;
      fetch_rsvd_q     <= 1'b0;
      data_rsvd_q      <= 1'b0;
      stall            <= 1'b0;
      boot_enable      <= 1'b0;
    end else begin
      st_q             <= st_d;
      own_fetch_q      <= own_fetch_d;
      ext_sel          <= ext_sel_d;
      ext_we           <= ext_we_d;
      ext_addr_top_bit <= top_d;
      ext_addr_low     <= low_d;
      ext_wdata        <= wdata_d;
      ext_fdone_q      <= ext_fdone_d;
      ext_ddone_q      <= ext_ddone_d;
      ext_hold_q       <= ext_hold_d;
      fetch_int_q      <= fetch_int_d;
      data_int_q       <= data_int_d;
      fetch_rsvd_q     <= fetch_rsvd_d;
      data_rsvd_q      <= data_rsvd_d;
      stall            <= stall_d;
      boot_enable      <= boot_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer registers; external results land two cycles after ext_ack
  logic [23:0] fetch_rdata_d, data_rdata_d;
  logic        fetch_valid_d, data_valid_d;
  // valid is a one-cycle pulse; rdata holds until the next answer

  always_comb begin
    fetch_valid_d = fetch_int_q || fetch_rsvd_q || ext_fdone_q;
    data_valid_d  = data_int_q || data_rsvd_q || ext_ddone_q;
    fetch_rdata_d = fetch_rdata;
    data_rdata_d  = data_rdata;
    if (fetch_int_q) begin
      fetch_rdata_d = ram_fetch;
    end else if (ext_fdone_q) begin
      fetch_rdata_d = ext_hold_q;
    end else if (fetch_rsvd_q) begin
      // a fixed word, so a reserved read never shows a stale bus value
      fetch_rdata_d = UNDEF_WORD;
    end
    if (data_int_q) begin
      data_rdata_d = ram_data;
    end else if (ext_ddone_q) begin
      data_rdata_d = ext_hold_q;
    end else if (data_rsvd_q) begin
      data_rdata_d = UNDEF_WORD;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fetch_rdata <= WORD_RESET;
      data_rdata  <= WORD_RESET;
      fetch_valid <= 1'b0;
      data_valid  <= 1'b0;
    end else begin
      fetch_rdata <= fetch_rdata_d;
      data_rdata  <= data_rdata_d;
      fetch_valid <= fetch_valid_d;
      data_valid  <= data_valid_d;
    end
  end
endmodule // program_memory_overlay_decoder

/* program_memory_overlay_decoder_tb_top.sv */
// table-driven bench for the overlay decoder
// assumes the external memory model holds A00000 plus address
`timescale 1ns/10ps
module program_memory_overlay_decoder_tb_top;
  import pm_overlay_pkg::*;
  logic sys_clk = 0, rst = 1, map_mode_pin = 0, fetch_req = 0, data_req = 0, data_we = 0;
  logic [1:0] program_overlay_select = 0;
  logic [13:0] fetch_addr = 0, data_addr = 0;
  logic [23:0] data_wdata = 0, fetch_rdata, data_rdata, ext_wdata, ext_rdata, rd;
  logic [3:0] wait_cycles = 4'h2;
  logic fetch_valid, data_valid, ext_sel, ext_we, ext_addr_top_bit, ext_ack;
  logic boot_enable, stall, ext, top;
  logic [12:0] ext_addr_low;
  int n_errors = 0;
  int checks_done = 0;
  typedef struct {
    logic [1:0] sel; logic fe; logic we; logic [13:0] a;
    logic [23:0] wd; logic ext; logic top; logic [23:0] rd;
  } row_s;
  row_s rows [9] = '{
    '{2'h0, 1'h0, 1'h1, 14'h1FFF, 24'h654321, 1'h0, 1'h0, 24'h0},
    '{2'h0, 1'h1, 1'h0, 14'h1FFF, 24'h0, 1'h0, 1'h0, 24'h654321},
    '{2'h1, 1'h1, 1'h0, 14'h2005, 24'h0, 1'h1, 1'h0, 24'hA00005},
    '{2'h2, 1'h1, 1'h0, 14'h3FFF, 24'h0, 1'h1, 1'h1, 24'hA03FFF},
    '{2'h2, 1'h0, 1'h1, 14'h2010, 24'h123456, 1'h1, 1'h1, 24'h0},
    '{2'h2, 1'h0, 1'h0, 14'h2010, 24'h0, 1'h1, 1'h1, 24'h123456},
    '{2'h1, 1'h0, 1'h0, 14'h2010, 24'h0, 1'h1, 1'h0, 24'hA00010},
    '{2'h3, 1'h1, 1'h0, 14'h2001, 24'h0, 1'h1, 1'h0, 24'hA00001},
    '{2'h1, 1'h0, 1'h0, 14'h1FFF, 24'h0, 1'h0, 1'h0, 24'h654321}};

  always #4 sys_clk = ~sys_clk;

  program_memory_overlay_decoder DUT (
    .sys_clk, .rst, .map_mode_pin, .program_overlay_select, .fetch_req, .fetch_addr,
    .fetch_rdata, .fetch_valid, .data_req, .data_we, .data_addr, .data_wdata,
    .data_rdata, .data_valid, .ext_sel, .ext_we, .ext_addr_top_bit, .ext_addr_low,
    .ext_wdata, .ext_ack, .ext_rdata, .boot_enable, .stall);
  pm_ext_overlay_mem u_mem (
    .sys_clk, .rst, .wait_cycles, .ext_sel, .ext_we, .ext_addr_top_bit,
    .ext_addr_low, .ext_wdata, .ext_ack, .ext_rdata);
  ////////////////////////////////////////////////////////////////
  task chk_word(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task chk_bit(input string what, input logic exp, input logic got);
    chk_word(what, {23'h0, exp}, {23'h0, got});
  endtask
  // one-cycle request, then watch the bus until the answer
  task access(input logic fe, input logic we, input logic [13:0] a, input logic [23:0] wd);
    logic got;
    got = 0;
    ext = 0;
    top = 0;
    @(posedge sys_clk);
    #1;
    {fetch_req, data_req, data_we} = {fe, !fe, we};
    {fetch_addr, data_addr, data_wdata} = {a, a, wd};
    @(posedge sys_clk);
    #1;
    {fetch_req, data_req} = 2'h0;
    for (int i = 0; i < 40 && !got; i++) begin
      @(posedge sys_clk);
      #1;
      if (ext_sel === 1'h1) {ext, top} = {1'h1, ext_addr_top_bit};
      if ((fe ? fetch_valid : data_valid) === 1'h1) got = 1;
      rd = fe ? fetch_rdata : data_rdata;
    end
    chk_bit("answer", 1'h1, got);
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    #1;
    chk_bit("ext_sel in reset", 1'h0, ext_sel);
    rst = 0;
    repeat (5) @(posedge sys_clk);
    #1;
    chk_bit("boot_enable", 1'h1, boot_enable);
    foreach (rows[i]) begin
      program_overlay_select = rows[i].sel;
      access(rows[i].fe, rows[i].we, rows[i].a, rows[i].wd);
      chk_bit("ext", rows[i].ext, ext);
      if (rows[i].ext) chk_bit("top", rows[i].top, top);
      if (!rows[i].we) chk_word("rdata", rows[i].rd, rd);
    end
    // both ports in one cycle
    {fetch_req, data_req, data_we, fetch_addr, data_addr} = {3'h6, 14'h1FFF, 14'h1FFF};
    @(posedge sys_clk);
    #1;
    {fetch_req, data_req} = 2'h0;
    // both answers stand in the same cycle, two cycles after the request
    @(posedge sys_clk);
    #1;
    chk_bit("dual valid", 1'h1, fetch_valid & data_valid);
    chk_word("dual data", 24'h654321, data_rdata);
    chk_word("dual fetch", 24'h654321, fetch_rdata);
    // slow far side
    wait_cycles = 4'h9;
    program_overlay_select = 2'h2;
    access(1'h1, 1'h0, 14'h2123, 24'h0);
    chk_word("slow rdata", 24'hA02123, rd);
    program_overlay_select = 2'h0;
    map_mode_pin = 1;
    repeat (6) @(posedge sys_clk);
    #1;
    chk_bit("boot off", 1'h0, boot_enable);
    access(1'h1, 1'h0, 14'h0004, 24'h0);
    chk_bit("low ext", 1'h1, ext);
    chk_word("low rdata", 24'hA00004, rd);
    access(1'h1, 1'h0, 14'h2004, 24'h0);
    chk_bit("reserved ext", 1'h0, ext);
    chk_word("reserved rdata", UNDEF_WORD, rd);
    tally_and_finish;
  end
endmodule // program_memory_overlay_decoder_tb_top
